// file: core/tle_encap.sv
// ts link encapsulator top: transmit framer plus receive restorer
// assumes ts bytes with a start mark on each sync byte, one clock
`timescale 1ns/100ps
`default_nettype none
module tle_encap
  import tle_pkg::*;
#(
  parameter int MAX_PKTS = MAX_TS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // transmit transport stream in
  input wire logic [7:0] tsData,
  input wire logic tsStart,
  input wire logic tsValid,
  output logic tsReady,
  input wire logic nullDelEn,
  input wire logic hdrDelEn,
  input wire logic flushReq,
  // transmit link packets out
  output logic [7:0] alpData,
  output logic alpLast,
  output logic alpValid,
  input wire logic alpReady,
  // receive link packets in
  input wire logic [7:0] rxAlpData,
  input wire logic rxAlpValid,
  output logic rxAlpReady,
  // receive transport stream out
  output logic [7:0] rxTsData,
  output logic rxTsStart,
  output logic rxTsValid,
  input wire logic rxTsReady
);

  localparam int CW = $clog2(MAX_PKTS + 1);
  localparam logic [CW-1:0] SLOT_MAX = CW'(MAX_PKTS);
  localparam logic [CW-1:0] ONE = CW'(1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    tle_tx_phase_type phase;
    logic [MAX_PKTS-1:0][PAYLOAD_LEN-1:0][7:0] mem;
    logic [7:0] byteIdx;
    logic dropping;
    logic [CW-1:0] pktCnt;
    logic [7:0] nullCnt;
    logic hdrRun;
    logic dupSeen;
    logic [CW-1:0] rdSlot;
    logic [7:0] rdByte;
    logic headerDeletionMode;
    logic [7:0] hdr0;
    logic [7:0] hdr1;
    logic tsReady;
  } tle_tx_type;

  tle_tx_type s;
  tle_tx_type next_s;

  logic accept;
  logic [7:0] idx;
  logic [8:0] bufInData;
  logic bufInValid;
  logic bufInReady;
  logic lastByte;
  logic [16:0] hdrWord;
  logic nullHere;
  logic [7:0] prev0;
  logic [7:0] prev1;
  logic [7:0] prev2;

  // ---------------------------------------------------------------
  // header build for a closing link packet
  // ---------------------------------------------------------------
  // returns {mode, base byte, extra byte} for cnt useful packets
  function automatic logic [16:0] build_hdr(input logic [CW-1:0] cnt, input logic [7:0] nulls,
                                            input logic run, input logic dup,
                                            input logic enable);
    logic mode;
    logic flag;
    logic [3:0] cnt4;
    mode = enable && run && !dup && (cnt > ONE) && (nulls != DELETED_NULL_FULL); // R6 R17 R18 R8
    flag = (nulls != 8'h00) || mode; // R4 R5
    cnt4 = 4'(cnt); // R3
    return {mode, TS_PKT_TYPE, cnt4, flag, mode, nulls[6:0]}; // R1 R2 R7 R12
  endfunction

  // ---------------------------------------------------------------
  // transmit framer
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    accept = tsValid && s.tsReady;
    idx = tsStart ? 8'h00 : s.byteIdx;
    bufInValid = 1'b0;
    bufInData = 9'h000;
    lastByte = 1'b0;
    hdrWord = 17'h00000;
    nullHere = 1'b0;
    prev0 = 8'h00;
    prev1 = 8'h00;
    prev2 = 8'h00;
    if (s.pktCnt != '0) begin
      prev0 = s.mem[s.pktCnt - ONE][0];
      prev1 = s.mem[s.pktCnt - ONE][1];
      prev2 = s.mem[s.pktCnt - ONE][2];
    end
    case (s.phase)
      TX_COLLECT: begin
        // flush only between packets, never mid-packet
        if (flushReq && idx == 8'h00 && s.pktCnt != '0 && !accept) begin
          hdrWord = build_hdr(s.pktCnt, s.nullCnt, s.hdrRun, s.dupSeen, hdrDelEn);
          next_s.headerDeletionMode = hdrWord[16];
          next_s.hdr0 = hdrWord[15:8];
          next_s.hdr1 = hdrWord[7:0];
          next_s.rdSlot = '0;
          next_s.rdByte = 8'h00;
          next_s.phase = TX_BASE;
        end
        if (accept) begin
          next_s.byteIdx = idx + 8'h01;
          if (idx == 8'h00) begin
            next_s.dropping = 1'b0; // R9
          end else if (!s.dropping && s.pktCnt != SLOT_MAX) begin
            next_s.mem[s.pktCnt][idx - 8'h01] = tsData; // R9
          end
          // null test comes before header comparison
          if (idx == 8'h02 && !s.dropping) begin // R11
            nullHere = tle_is_null(s.mem[s.pktCnt][0], tsData);
            if (nullHere && nullDelEn &&
                (s.pktCnt != '0 || s.nullCnt != DELETED_NULL_FULL)) begin // R10 R14
              next_s.dropping = 1'b1;
              if (s.pktCnt != '0) begin // R16 R15
                hdrWord = build_hdr(s.pktCnt, s.nullCnt, s.hdrRun, s.dupSeen, hdrDelEn);
                next_s.headerDeletionMode = hdrWord[16];
                next_s.hdr0 = hdrWord[15:8];
                next_s.hdr1 = hdrWord[7:0];
                next_s.rdSlot = '0;
                next_s.rdByte = 8'h00;
                next_s.phase = TX_BASE;
              end
            end
          end
          if (idx == HDR_BYTES && !s.dropping && s.pktCnt != '0) begin
            if (prev0 != s.mem[s.pktCnt][0] || prev1 != s.mem[s.pktCnt][1] ||
                prev2[7:4] != tsData[7:4] ||
                prev2[3:0] + 4'h1 != tsData[3:0]) begin // R17 R21
              next_s.hdrRun = 1'b0;
            end
            if (prev0 == s.mem[s.pktCnt][0] && prev1 == s.mem[s.pktCnt][1] &&
                prev2 == tsData) begin
              next_s.dupSeen = 1'b1; // R18
            end
          end
          if (idx == TS_LAST) begin
            next_s.byteIdx = 8'h00;
            if (next_s.dropping) begin
              next_s.dropping = 1'b0;
              next_s.nullCnt = s.nullCnt + 8'h01; // R12
            end else begin
              next_s.pktCnt = s.pktCnt + ONE;
              if (s.pktCnt + ONE == SLOT_MAX) begin
                hdrWord = build_hdr(SLOT_MAX, s.nullCnt, next_s.hdrRun, next_s.dupSeen,
                                    hdrDelEn);
                next_s.headerDeletionMode = hdrWord[16];
                next_s.hdr0 = hdrWord[15:8];
                next_s.hdr1 = hdrWord[7:0];
                next_s.rdSlot = '0;
                next_s.rdByte = 8'h00;
                next_s.phase = TX_BASE;
              end
            end
          end
        end
      end
      TX_BASE: begin
        bufInValid = 1'b1;
        bufInData = {1'b0, s.hdr0}; // R1 R2
        if (bufInReady) begin
          next_s.phase = s.hdr0[BASE_FLAG_BIT] ? TX_ADD : TX_DATA; // R4
        end
      end
      TX_ADD: begin
        bufInValid = 1'b1;
        bufInData = {1'b0, s.hdr1}; // R2
        if (bufInReady) begin
          next_s.phase = TX_DATA;
        end
      end
      TX_DATA: begin
        lastByte = (s.rdSlot + ONE == s.pktCnt) && (s.rdByte == PAY_LAST);
        bufInValid = 1'b1;
        bufInData = {lastByte, s.mem[s.rdSlot][s.rdByte]};
        if (bufInReady) begin
          next_s.rdByte = s.rdByte + 8'h01;
          if (s.rdByte == PAY_LAST) begin
            next_s.rdSlot = s.rdSlot + ONE;
            next_s.rdByte = s.headerDeletionMode ? HDR_BYTES : 8'h00; // R17
          end
          if (lastByte) begin
            next_s.phase = TX_COLLECT;
            next_s.pktCnt = '0;
            next_s.nullCnt = 8'h00; // R13
            next_s.hdrRun = 1'b1;
            next_s.dupSeen = 1'b0;
          end
        end
      end
      default: next_s.phase = TX_COLLECT;
    endcase
    next_s.tsReady = (next_s.phase == TX_COLLECT);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s <= '0;
      s.hdrRun <= 1'b1;
      s.tsReady <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign tsReady = s.tsReady;

  // ---------------------------------------------------------------
  // output buffering and receive path
  // ---------------------------------------------------------------
  tle_skid_buf #(
    .W(9)
  ) u_tx_buf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .inData(bufInData),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .outData({alpLast, alpData}),
    .outValid(alpValid),
    .outReady(alpReady)
  );

  tle_rx_restore u_rx (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .inData(rxAlpData),
    .inValid(rxAlpValid),
    .inReady(rxAlpReady),
    .outData(rxTsData),
    .outStart(rxTsStart),
    .outValid(rxTsValid),
    .outReady(rxTsReady)
  );

endmodule
`default_nettype wire

// file: core/tle_pkg.sv
// shared constants, field layouts and state types of the ts link encapsulator
// assumes byte-wide transport and link streams on a single clock
//
// How it works
// R1 - base header packet type is 111
// R2 - base byte type/count/flag, extra byte mode/count
// R3 - count field 0 means sixteen packets
// R4 - extra byte present only when flag set
// R5 - flag set when nulls deleted or headers deleted
// R6 - deletion mode one only when headers removed
// R7 - mode 0 with count 0 means 128
// R8 - mode 1 with count 0 means none
// R9 - sync byte dropped, 187 bytes per packet
// R10 - null packets (pid 1fff) may be dropped
// R11 - sync, then nulls, then common headers
// R12 - null counter cleared, counts leading dropped nulls
// R13 - null counter zeroed after packet handed over
// R14 - null at full counter kept as useful
// R15 - every link packet holds a useful packet
// R16 - null after useful packets closes the packet
// R17 - sequential matching headers sent only once
// R18 - duplicates forbid header deletion
// R19 - receiver rebuilds headers, counter plus one
// R20 - receiver reinserts nulls where removed
// R21 - counter wraps at sixteen, sync restored
package tle_pkg;

  localparam logic [2:0] TS_PKT_TYPE = 3'h7;
  localparam logic [7:0] SYNC_BYTE = 8'h47;
  localparam logic [12:0] NULL_PID = 13'h1fff;
  localparam logic [7:0] NULL_HDR_LAST = 8'h10;
  localparam logic [7:0] STUFF_BYTE = 8'hff;

  localparam int TS_LEN = 188;
  localparam int PAYLOAD_LEN = TS_LEN - 1;
  localparam int HDR_LEN = 3;
  localparam int MAX_TS = 16;
  localparam int DELETED_NULL_MAX = 128;

  localparam logic [7:0] TS_LAST = 8'(TS_LEN - 1);
  localparam logic [7:0] PAY_LAST = 8'(PAYLOAD_LEN - 1);
  localparam logic [7:0] HDR_BYTES = 8'(HDR_LEN);
  localparam logic [7:0] DELETED_NULL_FULL = 8'(DELETED_NULL_MAX);

  // field positions
  localparam int BASE_FLAG_BIT = 0;
  localparam int BASE_COUNT_LSB = 1;
  localparam int ADD_MODE_BIT = 7;
  localparam int CC_LSB = 0;

  typedef enum logic [1:0] {
    TX_COLLECT = 2'h0,
    TX_BASE = 2'h1,
    TX_ADD = 2'h3,
    TX_DATA = 2'h2
  } tle_tx_phase_type;

  typedef enum logic [2:0] {
    RX_BASE = 3'h0,
    RX_ADD = 3'h1,
    RX_NULL = 3'h3,
    RX_SYNC = 3'h2,
    RX_HDR = 3'h6,
    RX_PAY = 3'h7
  } tle_rx_phase_type;

  // null pid test of a packet from its first two header bytes after sync
  function automatic logic tle_is_null(input logic [7:0] b1, input logic [7:0] b2);
    return {b1[4:0], b2} == NULL_PID;
  endfunction

endpackage

// file: core/tle_skid_buf.sv
// two-entry valid/ready buffer with registered outputs
// assumes one clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module tle_skid_buf
  import tle_pkg::*;
#(
  parameter int W = 9
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  typedef struct packed {
    logic outValid;
    logic [W-1:0] outData;
    logic skidValid;
    logic [W-1:0] skidData;
    logic inReady;
  } tle_buf_type;

  tle_buf_type s;
  tle_buf_type next_s;

  always_comb begin
    next_s = s;
    if (s.outValid && outReady) begin
      next_s.outValid = 1'b0;
    end
    if (!next_s.outValid && next_s.skidValid) begin
      next_s.outValid = 1'b1;
      next_s.outData = next_s.skidData;
      next_s.skidValid = 1'b0;
    end
    if (inValid && s.inReady) begin
      if (!next_s.outValid) begin
        next_s.outValid = 1'b1;
        next_s.outData = inData;
      end else begin
        next_s.skidValid = 1'b1;
        next_s.skidData = inData;
      end
    end
    next_s.inReady = !next_s.skidValid;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign inReady = s.inReady;
  assign outData = s.outData;
  assign outValid = s.outValid;

endmodule
`default_nettype wire

// file: core/tle_rx_restore.sv
// receive side: link packets back to a full transport stream
// assumes link bytes arrive in order, each link packet whole
`timescale 1ns/100ps
`default_nettype none
module tle_rx_restore
  import tle_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [7:0] outData,
  output logic outStart,
  output logic outValid,
  input wire logic outReady
);

  typedef struct packed {
    tle_rx_phase_type phase;
    logic [7:0] hold;
    logic holdValid;
    logic inReady;
    logic [4:0] tsPacketCount;
    logic headerDeletionMode;
    logic [7:0] nullLeft;
    logic [7:0] byteCnt;
    logic [4:0] pkt;
    logic [2:0][7:0] hdr;
    logic [7:0] outData;
    logic outStart;
    logic outValid;
  } tle_rx_type;

  tle_rx_type s;
  tle_rx_type next_s;
  logic go;
  logic consume;

  always_comb begin
    next_s = s;
    consume = 1'b0;
    go = !s.outValid || outReady;
    if (s.outValid && outReady) begin
      next_s.outValid = 1'b0;
    end
    if (go) begin
      next_s.outStart = 1'b0;
      case (s.phase)
        RX_BASE: begin
          if (s.holdValid) begin
            consume = 1'b1;
            next_s.tsPacketCount = {s.hold[4:1] == 4'h0, s.hold[4:1]};
            next_s.headerDeletionMode = 1'b0;
            next_s.nullLeft = 8'h00;
            next_s.pkt = 5'h00;
            next_s.phase = s.hold[BASE_FLAG_BIT] ? RX_ADD : RX_SYNC;
          end
        end
        RX_ADD: begin
          if (s.holdValid) begin
            consume = 1'b1;
            next_s.headerDeletionMode = s.hold[ADD_MODE_BIT];
            next_s.byteCnt = 8'h00;
            if (s.hold[6:0] != 7'h00) begin
              next_s.nullLeft = {1'b0, s.hold[6:0]};
            end else begin
              next_s.nullLeft = s.hold[ADD_MODE_BIT] ? 8'h00 : DELETED_NULL_FULL; // R7 R8
            end
            next_s.phase = (next_s.nullLeft != 8'h00) ? RX_NULL : RX_SYNC;
          end
        end
        RX_NULL: begin
          next_s.outValid = 1'b1; // R20
          next_s.outStart = (s.byteCnt == 8'h00);
          case (s.byteCnt)
            8'h00: next_s.outData = SYNC_BYTE;
            8'h01: next_s.outData = {3'h0, NULL_PID[12:8]};
            8'h02: next_s.outData = NULL_PID[7:0];
            8'h03: next_s.outData = NULL_HDR_LAST;
            default: next_s.outData = STUFF_BYTE;
          endcase
          next_s.byteCnt = s.byteCnt + 8'h01;
          if (s.byteCnt == TS_LAST) begin
            next_s.byteCnt = 8'h00;
            next_s.nullLeft = s.nullLeft - 8'h01;
            if (s.nullLeft == 8'h01) begin
              next_s.phase = RX_SYNC;
            end
          end
        end
        RX_SYNC: begin
          next_s.outValid = 1'b1;
          next_s.outStart = 1'b1;
          next_s.outData = SYNC_BYTE; // R21
          next_s.byteCnt = 8'h00;
          next_s.phase = (s.headerDeletionMode && s.pkt != 5'h00) ? RX_HDR : RX_PAY;
        end
        RX_HDR: begin
          next_s.outValid = 1'b1;
          if (s.byteCnt == HDR_BYTES - 8'h01) begin
            next_s.outData = {s.hdr[2][7:4], s.hdr[2][3:0] + s.pkt[3:0]}; // R19 R21
            next_s.phase = RX_PAY;
          end else begin
            next_s.outData = s.hdr[s.byteCnt[1:0]]; // R19
          end
          next_s.byteCnt = s.byteCnt + 8'h01;
        end
        RX_PAY: begin
          if (s.holdValid) begin
            consume = 1'b1;
            next_s.outValid = 1'b1;
            next_s.outData = s.hold;
            if (s.pkt == 5'h00 && s.byteCnt < HDR_BYTES) begin
              next_s.hdr[s.byteCnt[1:0]] = s.hold;
            end
            next_s.byteCnt = s.byteCnt + 8'h01;
            if (s.byteCnt == PAY_LAST) begin
              next_s.byteCnt = 8'h00;
              next_s.pkt = s.pkt + 5'h01;
              next_s.phase = (s.pkt + 5'h01 == s.tsPacketCount) ? RX_BASE : RX_SYNC;
            end
          end
        end
        default: next_s.phase = RX_BASE;
      endcase
    end
    if (consume) begin
      next_s.holdValid = 1'b0;
    end
    if (inValid && s.inReady) begin
      next_s.hold = inData;
      next_s.holdValid = 1'b1;
    end
    next_s.inReady = !next_s.holdValid;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign inReady = s.inReady;
  assign outData = s.outData;
  assign outStart = s.outStart;
  assign outValid = s.outValid;

endmodule
`default_nettype wire

// file: bench/tle_encap_properties.sv
// checker on the encapsulator top ports
// assumes one clock domain, bound into every tle_encap
`timescale 1ns/100ps
`default_nettype none
module tle_encap_checker
  import tle_pkg::*;
#(
  parameter int MAX_PKTS = MAX_TS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic tsReady,
  input wire logic [7:0] alpData,
  input wire logic alpLast,
  input wire logic alpValid,
  input wire logic alpReady,
  input wire logic [7:0] rxTsData,
  input wire logic rxTsStart,
  input wire logic rxTsValid,
  input wire logic rxTsReady
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic atStart;
  logic next_atStart;
  // ------------------------------
  // first byte of a link packet
  // ------------------------------
  always_comb begin
    next_atStart = atStart;
    if (alpValid && alpReady) begin
      next_atStart = alpLast;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      atStart <= 1'b1;
    end else begin
      atStart <= next_atStart;
    end
  end
  sequence s_hdr;
    alpValid && atStart;
  endsequence
  sequence s_alp_stall;
    alpValid && !alpReady;
  endsequence
  property p_alp_hold;
    s_alp_stall |=> alpValid && $stable(alpData) && $stable(alpLast);
  endproperty
  property p_rx_hold;
    rxTsValid && !rxTsReady |=> rxTsValid && $stable(rxTsData) && $stable(rxTsStart);
  endproperty
  property p_type;
    s_hdr |-> alpData[7:5] == TS_PKT_TYPE;
  endproperty
  property p_count;
    s_hdr |-> ((alpData[4:1] == 4'h0) ? (MAX_PKTS == 16) : (int'(alpData[4:1]) <= MAX_PKTS));
  endproperty
  property p_hdr_not_last;
    s_hdr |-> !alpLast;
  endproperty
  property p_sync;
    rxTsValid && rxTsStart |-> rxTsData == SYNC_BYTE;
  endproperty
  property p_emit;
    $fell(tsReady) |-> ##[1:4] alpValid;
  endproperty
  property p_reset;
    disable iff (1'b0) !nrst |=> tsReady && !alpValid && !rxTsValid;
  endproperty
  a_alp_hold: assert property (p_alp_hold) else $error("link byte changed while stalled");
  a_rx_hold: assert property (p_rx_hold) else $error("ts byte changed while stalled");
  a_type: assert property (p_type) else $error("wrong packet type");
  a_count: assert property (p_count) else $error("packet count out of range");
  a_hdr_not_last: assert property (p_hdr_not_last) else $error("link packet without payload");
  a_sync: assert property (p_sync) else $error("restored start byte not sync");
  a_emit: assert property (p_emit) else $error("closed packet not emitted");
  a_reset: assert property (p_reset) else $error("bad reset state");
endmodule
bind tle_encap tle_encap_checker #(.MAX_PKTS(MAX_PKTS)) u_tle_encap_checker (
  .ref_clk(ref_clk), .nrst(nrst), .tsReady(tsReady), .alpData(alpData),
  .alpLast(alpLast), .alpValid(alpValid), .alpReady(alpReady), .rxTsData(rxTsData),
  .rxTsStart(rxTsStart), .rxTsValid(rxTsValid), .rxTsReady(rxTsReady)
);
`default_nettype wire

// file: bench/tle_phy_model.sv
// physical layer model: stalls link bytes, checks frame length, loops back
// assumes link out and link in of the same encapsulator
`timescale 1ns/100ps
`default_nettype none
module tle_phy_model
  import tle_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [7:0] alpData,
  input wire logic alpLast,
  input wire logic alpValid,
  output logic alpReady,
  output logic [7:0] rxAlpData,
  output logic rxAlpValid,
  input wire logic rxAlpReady,
  output logic [15:0] nBad,
  output logic [15:0] nChk
);
  integer seed = 81;
  logic go = 1'b0;
  logic hold;
  logic [7:0] base = 8'h00;
  logic [7:0] extra = 8'h00;
  int idx = 0;
  int num;
  int expLen;
  assign alpReady = go && rxAlpReady;
  assign rxAlpValid = go && alpValid;
  // withheld data shows the inverse, never the last value
  assign rxAlpData = rxAlpValid ? alpData : ~alpData;
  initial begin
    nBad = 16'h0000;
    nChk = 16'h0000;
  end
  always @(posedge ref_clk) begin
    hold = rxAlpValid && !rxAlpReady;
    if (alpValid && alpReady) begin
      if (idx == 0) begin
        base = alpData;
        extra = 8'h00;
        nChk++;
        if (alpData[7:5] !== 3'h7) begin
          nBad++;
          $display("ERROR link type expected 7 seen %h", alpData[7:5]);
        end
      end
      if (idx == 1 && base[0]) begin
        extra = alpData;
      end
      if (alpLast) begin
        num = (base[4:1] == 4'h0) ? 16 : int'(base[4:1]);
        expLen = 188 + int'(base[0]) + (num - 1) * (extra[7] ? 184 : 187);
        nChk++;
        if (idx + 1 != expLen || (extra[7] && num < 2)) begin
          nBad++;
          $display("ERROR link length expected %0d seen %0d", expLen, idx + 1);
        end
      end
      idx = alpLast ? 0 : idx + 1;
    end
    #1;
    if (!hold) begin
      go = ($random(seed) & 3) != 0;
    end
  end
endmodule
`default_nettype wire

// file: bench/test_tle_encap.sv
// self-checking bench: random ts stream through framer, loopback, restorer
// assumes restored stream equals the sent one byte for byte
`timescale 1ns/100ps
`default_nettype none
module test_tle_encap;
  import tle_pkg::*;
  localparam int NPK = 4;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [7:0] tsData = 8'h00;
  logic tsStart = 1'b0;
  logic tsValid = 1'b0;
  logic nullDelEn = 1'b0;
  logic hdrDelEn = 1'b0;
  logic flushReq = 1'b0;
  logic rxTsReady = 1'b0;
  wire logic tsReady, alpLast, alpValid, alpReady, rxAlpValid, rxAlpReady;
  wire logic rxTsStart, rxTsValid;
  wire logic [7:0] alpData, rxAlpData, rxTsData;
  wire logic [15:0] phyBad, phyChk;
  integer seed = 80;
  integer seedRdy = 83;
  int errors = 0;
  int n_compared = 0;
  int outIdx = 0;
  logic [7:0] expQ[$];
  logic [7:0] hdr[1:3];
  always #20 ref_clk = ~ref_clk;
  tle_encap #(.MAX_PKTS(NPK)) u_tle_encap (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .tsData(tsData), .tsStart(tsStart),
    .tsValid(tsValid), .tsReady(tsReady), .nullDelEn(nullDelEn), .hdrDelEn(hdrDelEn),
    .flushReq(flushReq), .alpData(alpData), .alpLast(alpLast), .alpValid(alpValid),
    .alpReady(alpReady), .rxAlpData(rxAlpData), .rxAlpValid(rxAlpValid),
    .rxAlpReady(rxAlpReady), .rxTsData(rxTsData), .rxTsStart(rxTsStart),
    .rxTsValid(rxTsValid), .rxTsReady(rxTsReady)
  );
  tle_phy_model u_tle_phy_model (
    .ref_clk(ref_clk), .alpData(alpData), .alpLast(alpLast), .alpValid(alpValid),
    .alpReady(alpReady), .rxAlpData(rxAlpData), .rxAlpValid(rxAlpValid),
    .rxAlpReady(rxAlpReady), .nBad(phyBad), .nChk(phyChk)
  );
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    errors = errors + int'(phyBad);
    $display("compared %0d link checks %0d errors %0d", n_compared, phyChk, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // kind: 0 null, 1 run with cc plus one, 2 duplicate, 3 new header
  function automatic int pick();
    int r;
    r = $random(seed) & 7;
    return (r < 2) ? 0 : (r < 5) ? 1 : (r == 5) ? 2 : 3;
  endfunction
  function automatic logic [7:0] exp_byte(input int kind, input int i, input logic [7:0] rnd);
    if (i == 0) return SYNC_BYTE;
    if (kind == 0) return (i == 1) ? 8'h1f : (i == 3) ? NULL_HDR_LAST : STUFF_BYTE;
    if (i < 4) return hdr[i];
    return rnd;
  endfunction
  task automatic send_pkt(input int kind);
    logic [7:0] b;
    int n;
    if (kind == 1) begin
      hdr[3][3:0] = hdr[3][3:0] + 4'h1;
    end else if (kind == 3) begin
      hdr[1] = 8'($random(seed)) & 8'hef;
      hdr[2] = 8'($random(seed));
      hdr[3] = 8'($random(seed));
    end
    for (int i = 0; i < TS_LEN; i++) begin
      b = exp_byte(kind, i, 8'($random(seed)));
      expQ.push_back(b);
      tsData = b;
      tsStart = (i == 0);
      tsValid = 1'b1;
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (!tsReady && n < 40000);
      if (n >= 40000) begin
        errors++;
        $display("ERROR tsReady timeout");
        tally_and_finish();
      end
      #1;
    end
  endtask
  task automatic flush_drain();
    int n;
    tsValid = 1'b0;
    flushReq = 1'b1;
    n = 0;
    while (expQ.size() > 0 && n < 40000) begin
      @(posedge ref_clk);
      n++;
    end
    #1;
    flushReq = 1'b0;
    if (n >= 40000) begin
      errors++;
      $display("ERROR drain timeout, left %0d", expQ.size());
      tally_and_finish();
    end
  endtask
  // ------------------------------
  // restored stream monitor
  // ------------------------------
  always @(posedge ref_clk) begin
    if (nrst && rxTsValid && rxTsReady) begin
      if (expQ.size() == 0) begin
        errors++;
        $display("ERROR rxTsData expected none seen %h", rxTsData);
      end else begin
        check8("rxTsData", expQ.pop_front(), rxTsData);
      end
      check8("rxTsStart", {7'h0, outIdx == 0}, {7'h0, rxTsStart});
      outIdx = (outIdx + 1) % TS_LEN;
    end
    #1;
    rxTsReady = ($random(seedRdy) & 3) != 0;
  end
  // ------------------------------
  // scenarios
  // ------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    // nothing deleted, nulls travel as useful packets
    send_pkt(3);
    for (int k = 0; k < 14; k++) send_pkt(pick());
    send_pkt(3);
    flush_drain();
    nullDelEn = 1'b1;
    hdrDelEn = 1'b1;
    for (int k = 0; k < 30; k++) send_pkt(pick());
    send_pkt(3);
    flush_drain();
    // duplicates then a run longer than one link packet
    send_pkt(3);
    send_pkt(2);
    send_pkt(2);
    for (int k = 0; k < NPK + 2; k++) send_pkt(1);
    flush_drain();
    // null counter overflow keeps one null as useful
    for (int k = 0; k < 130; k++) send_pkt(0);
    send_pkt(3);
    send_pkt(1);
    flush_drain();
    tally_and_finish();
  end
endmodule
`default_nettype wire
